// ### hdl/etct_regs.svh
`ifndef ETCT_REGS_SVH
`define ETCT_REGS_SVH
// Register byte offsets
`define ETCT_OFF_CTRL 8'h00
`define ETCT_OFF_VBASE 8'h04
`define ETCT_OFF_VNUM 8'h08
`define ETCT_OFF_STATUS 8'h0C
`define ETCT_OFF_ISTAT 8'h10
`define ETCT_OFF_ICLR 8'h14
`define ETCT_OFF_IEN 8'h18
// Control fields
`define ETCT_CTRL_TRIG 0
`define ETCT_CTRL_START 1
`define ETCT_CTRL_CONT 2
// Status fields
`define ETCT_ST_FLAG 0
`define ETCT_ST_BUSY 1
`define ETCT_ST_EXH 2
// Interrupt status bits
`define ETCT_IRQ_CONV 0
`define ETCT_IRQ_DONE 1
// Reset values
`define ETCT_RST_VBASE 32'h00000000
`define ETCT_RST_VNUM 8'h00
// Vector table placement
`define ETCT_VEC_OFS 32'h00000400
`define ETCT_VEC_SHIFT 2
// Control-information set: three words, word 0 layout
`define ETCT_SET_LAST 2'h2
`define ETCT_SET_BYTES 32'h0000000C
`define ETCT_W0_SZ_LSB 16
`define ETCT_W0_SRC_INC 18
`define ETCT_W0_DST_INC 19
`define ETCT_W0_CHAIN 20
`endif

// ### hdl/etct_pkg.sv
package etct_pkg;
   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_REQ = 8'h02,
      ST_VEC = 8'h04,
      ST_RDCTL = 8'h08,
      ST_RDDAT = 8'h10,
      ST_WRDAT = 8'h20,
      ST_WB = 8'h40,
      ST_REL = 8'h80
   } etct_state_type;
   // Transfer unit size
   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_LONG = 2'h2
   } etct_size_type;
endpackage : etct_pkg

// ### hdl/etct_conv_if.sv
`timescale 1ns/100ps
`default_nettype none
// Links the sequencer to the converter flag unit
interface etct_conv_if;
   logic done;
   logic rd_clr;
   logic sw_clr;
   logic start_wr;
   logic start_val;
   logic continuous;
   logic flag;
   logic start_bit;
   modport conv (input done, rd_clr, sw_clr, start_wr, start_val, continuous, output flag, start_bit);
   modport ctrl (output done, rd_clr, sw_clr, start_wr, start_val, continuous, input flag, start_bit);
endinterface : etct_conv_if
`default_nettype wire

// ### hdl/etct_conv_unit.sv
`timescale 1ns/100ps
`default_nettype none
module etct_conv_unit
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sequencer side
   etct_conv_if.conv cif
);
   logic flag_q;
   logic flag_d;
   logic start_q;
   logic start_d;
   // ============================================================
   // End flag and start bit
   // A new conversion end beats a clear in the same cycle
   assign flag_d = cif.done | (flag_q & ~cif.rd_clr & ~cif.sw_clr);
   // Continuous scan keeps the start bit; single scan drops it
   assign start_d = cif.start_wr ? cif.start_val : (start_q & ~(cif.done & ~cif.continuous));
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flag_q <= 1'b0;
         start_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
         start_q <= start_d;
      end
   end
   assign cif.flag = flag_q;
   assign cif.start_bit = start_q;
   chk_flag_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      cif.done |=> flag_q) else $error("end flag lost a conversion end");
   chk_scan_keeps_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (cif.done && cif.continuous && start_q && !cif.start_wr) |=> start_q)
      else $error("start bit dropped in continuous scan");
endmodule : etct_conv_unit
`default_nettype wire

// ### hdl/etct_ctrl.sv
// Operation
// - Conversion end sets the end flag, raising a request that activates transfers when enabled.
// - A request routed to the transfer controller never reaches the CPU interrupt; the release sets ISTAT bit 1, raising irq_o when IEN bit 1 is set.
// - The controller takes internal bus mastership before any vector, control or data access.
// - Vector address is base plus 0x400 plus vector number times four.
// - The fetched vector points to the control-information set that is then read.
// - Each set moves one unit of its size from source to destination.
// - Updated control information is written back after each data transfer.
// - With chaining set, the next set is read and moved in the same activation.
// - The bus is released only after the last set's write-back completes.
// - Reading a converter result register clears the end flag automatically.
// - Continuous scan keeps the start bit set and keeps converting.
// - Flag after count exhaustion clears trigger enable and interrupts the CPU.
// - The count is sixteen bits, zero meaning 65536, decremented per transfer.
// - Mode, address and count live in RAM, loaded on activation, written back.
// - The vector base is a 32-bit software-writable register.
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`include "etct_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module etct_ctrl #(
   parameter logic [31:0] RES_CH0_ADDR = 32'h00010000,
   parameter logic [31:0] RES_CH1_ADDR = 32'h00010004
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Converter
   input wire logic conv_done_i,
   output logic conv_start_o,
   // Internal bus master
   output logic mbus_req_o,
   input wire logic mbus_gnt_i,
   output logic mbus_stb_o,
   output logic mbus_we_o,
   output logic [1:0] mbus_size_o,
   output logic [31:0] mbus_addr_o,
   output logic [31:0] mbus_wdata_o,
   input wire logic [31:0] mbus_rdata_i,
   input wire logic mbus_ack_i,
   // Interrupt
   output logic irq_o
);
   etct_conv_if cif ();
   etct_pkg::etct_state_type st_q;
   etct_pkg::etct_state_type st_d;
   logic trig_q;
   logic cont_q;
   logic exh_q;
   logic served_q;
   logic first_q;
   logic [31:0] vbase_q;
   logic [7:0] vnum_q;
   logic [1:0] istat_q;
   logic [1:0] ien_q;
   logic [1:0] widx_q;
   logic [31:0] cia_q;
   logic [31:0] w0_q;
   logic [31:0] sar_q;
   logic [31:0] dar_q;
   logic [31:0] data_q;
   logic wb_ack_q;
   logic [31:0] wb_dat_q;

   // ============================================================
   // Register decode
   wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_q;
   wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
   wire wr_ctrl = wb_wr & (wb_adr_i == `ETCT_OFF_CTRL);
   wire wr_vbase = wb_hit & wb_we_i & (wb_adr_i == `ETCT_OFF_VBASE);
   wire wr_vnum = wb_wr & (wb_adr_i == `ETCT_OFF_VNUM);
   wire wr_iclr = wb_wr & (wb_adr_i == `ETCT_OFF_ICLR);
   wire wr_ien = wb_wr & (wb_adr_i == `ETCT_OFF_IEN);
   wire [1:0] iclr = wr_iclr ? wb_dat_i[1:0] : 2'h0;
   wire [31:0] ctrl_rd = {29'h0, cont_q, cif.start_bit, trig_q};
   wire [31:0] stat_rd = {29'h0, exh_q, (st_q != etct_pkg::ST_IDLE), cif.flag};
   wire [31:0] rd_mux =
      (wb_adr_i == `ETCT_OFF_CTRL) ? ctrl_rd :
      (wb_adr_i == `ETCT_OFF_VBASE) ? vbase_q :
      (wb_adr_i == `ETCT_OFF_VNUM) ? {24'h0, vnum_q} :
      (wb_adr_i == `ETCT_OFF_STATUS) ? stat_rd :
      (wb_adr_i == `ETCT_OFF_ISTAT) ? {30'h0, istat_q} :
      (wb_adr_i == `ETCT_OFF_IEN) ? {30'h0, ien_q} : 32'h00000000;

   // Byte-lane merge for the 32-bit vector base
   wire [31:0] vbase_d;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_lane
         assign vbase_d[8*gi +: 8] = wb_sel_i[gi] ? wb_dat_i[8*gi +: 8] : vbase_q[8*gi +: 8];
      end
   endgenerate

   // ============================================================
   // Request routing
   // The request goes to the controller only while armed and not exhausted
   wire armed = trig_q & ~exh_q;
   wire idle = (st_q == etct_pkg::ST_IDLE);
   // A request held during a sequence is seen here once idle again
   wire act_go = idle & cif.flag & armed;
   // Served once per flag episode so the status bit is not re-set each cycle
   wire cpu_evt = idle & cif.flag & ~armed & ~served_q;

   // ============================================================
   // Sequencer address and data
   wire [31:0] vec_addr = vbase_q + `ETCT_VEC_OFS + {22'h0, vnum_q, 2'h0};
   wire [31:0] ctl_addr = cia_q + {28'h0, widx_q, 2'h0};
   wire [1:0] sz = w0_q[`ETCT_W0_SZ_LSB +: 2];
   wire [31:0] step = (sz == etct_pkg::SZ_BYTE) ? 32'h00000001 :
                      (sz == etct_pkg::SZ_WORD) ? 32'h00000002 : 32'h00000004;
   // A count of zero wraps to all ones, giving 65536 transfers
   wire [15:0] cnt_dec = w0_q[15:0] - 16'h0001;
   wire dat_done = (st_q == etct_pkg::ST_WRDAT) & mbus_ack_i;
   wire wb_last = (st_q == etct_pkg::ST_WB) & mbus_ack_i & (widx_q == `ETCT_SET_LAST);
   wire rd_result = (st_q == etct_pkg::ST_RDDAT) & mbus_ack_i &
                    ((sar_q == RES_CH0_ADDR) | (sar_q == RES_CH1_ADDR));
   wire [31:0] wb_word = (widx_q == 2'h0) ? w0_q : (widx_q == 2'h1) ? sar_q : dar_q;
   wire access = (st_q == etct_pkg::ST_VEC) | (st_q == etct_pkg::ST_RDCTL) |
                 (st_q == etct_pkg::ST_RDDAT) | (st_q == etct_pkg::ST_WRDAT) |
                 (st_q == etct_pkg::ST_WB);

   // ============================================================
   // Next state
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         etct_pkg::ST_IDLE:
         begin
            if (act_go)
            begin
               st_d = etct_pkg::ST_REQ;
            end
         end
         etct_pkg::ST_REQ:
         begin
            // No access goes out before the grant
            if (mbus_gnt_i)
            begin
               st_d = etct_pkg::ST_VEC;
            end
         end
         etct_pkg::ST_VEC:
         begin
            if (mbus_ack_i)
            begin
               st_d = etct_pkg::ST_RDCTL;
            end
         end
         etct_pkg::ST_RDCTL:
         begin
            if (mbus_ack_i && widx_q == `ETCT_SET_LAST)
            begin
               st_d = etct_pkg::ST_RDDAT;
            end
         end
         etct_pkg::ST_RDDAT:
         begin
            if (mbus_ack_i)
            begin
               st_d = etct_pkg::ST_WRDAT;
            end
         end
         etct_pkg::ST_WRDAT:
         begin
            if (mbus_ack_i)
            begin
               st_d = etct_pkg::ST_WB;
            end
         end
         etct_pkg::ST_WB:
         begin
            if (wb_last)
            begin
               st_d = w0_q[`ETCT_W0_CHAIN] ? etct_pkg::ST_RDCTL : etct_pkg::ST_REL;
            end
         end
         etct_pkg::ST_REL:
         begin
            st_d = etct_pkg::ST_IDLE;
         end
         default:
         begin
            st_d = etct_pkg::ST_IDLE;
         end
      endcase
   end

   // ============================================================
   // Sequencer registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= etct_pkg::ST_IDLE;
         widx_q <= 2'h0;
         cia_q <= 32'h00000000;
         first_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         if (st_q == etct_pkg::ST_VEC && mbus_ack_i)
         begin
            cia_q <= mbus_rdata_i;
         end
         else if (wb_last)
         begin
            cia_q <= cia_q + `ETCT_SET_BYTES;
         end
         if ((st_q == etct_pkg::ST_RDCTL || st_q == etct_pkg::ST_WB) && mbus_ack_i)
         begin
            widx_q <= (widx_q == `ETCT_SET_LAST) ? 2'h0 : widx_q + 2'h1;
         end
         if (idle)
         begin
            first_q <= 1'b1;
         end
         else if (wb_last)
         begin
            first_q <= 1'b0;
         end
      end
   end

   // Working copy of the set: loaded from RAM, updated after the move
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         w0_q <= 32'h00000000;
         sar_q <= 32'h00000000;
         dar_q <= 32'h00000000;
         data_q <= 32'h00000000;
      end
      else if (st_q == etct_pkg::ST_RDCTL && mbus_ack_i)
      begin
         case (widx_q)
            2'h0: w0_q <= mbus_rdata_i;
            2'h1: sar_q <= mbus_rdata_i;
            default: dar_q <= mbus_rdata_i;
         endcase
      end
      else if (st_q == etct_pkg::ST_RDDAT && mbus_ack_i)
      begin
         data_q <= mbus_rdata_i;
      end
      else if (dat_done)
      begin
         w0_q <= {w0_q[31:16], cnt_dec};
         sar_q <= w0_q[`ETCT_W0_SRC_INC] ? sar_q + step : sar_q;
         dar_q <= w0_q[`ETCT_W0_DST_INC] ? dar_q + step : dar_q;
      end
   end

   // ============================================================
   // Arming, exhaustion and interrupt state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trig_q <= 1'b0;
         cont_q <= 1'b0;
         exh_q <= 1'b0;
         served_q <= 1'b0;
         istat_q <= 2'h0;
         ien_q <= 2'h0;
         vbase_q <= `ETCT_RST_VBASE;
         vnum_q <= `ETCT_RST_VNUM;
      end
      else
      begin
         // Hardware disarm wins over a software write in the same cycle
         if (cpu_evt)
         begin
            trig_q <= 1'b0;
         end
         else if (wr_ctrl)
         begin
            trig_q <= wb_dat_i[`ETCT_CTRL_TRIG];
         end
         if (wr_ctrl)
         begin
            cont_q <= wb_dat_i[`ETCT_CTRL_CONT];
         end
         // The first set's count running out ends this arming
         if (dat_done && first_q && cnt_dec == 16'h0000)
         begin
            exh_q <= 1'b1;
         end
         else if (wr_ctrl && wb_dat_i[`ETCT_CTRL_TRIG])
         begin
            exh_q <= 1'b0;
         end
         served_q <= cif.flag & (served_q | cpu_evt);
         istat_q <= (istat_q & ~iclr) | {(st_q == etct_pkg::ST_REL), cpu_evt};
         if (wr_ien)
         begin
            ien_q <= wb_dat_i[1:0];
         end
         if (wr_vbase)
         begin
            vbase_q <= vbase_d;
         end
         if (wr_vnum)
         begin
            vnum_q <= wb_dat_i[7:0];
         end
      end
   end

   // ============================================================
   // Wishbone answer: one wait state, unmapped reads return zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h00000000;
      end
      else
      begin
         wb_ack_q <= wb_hit;
         wb_dat_q <= wb_hit ? rd_mux : 32'h00000000;
      end
   end

   // ============================================================
   // Converter flag unit
   assign cif.done = conv_done_i;
   assign cif.rd_clr = rd_result;
   assign cif.sw_clr = iclr[`ETCT_IRQ_CONV];
   assign cif.start_wr = wr_ctrl;
   assign cif.start_val = wb_dat_i[`ETCT_CTRL_START];
   assign cif.continuous = cont_q;
   etct_conv_unit u_conv (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cif (cif)
   );

   // ============================================================
   // Outputs
   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign conv_start_o = cif.start_bit;
   assign mbus_req_o = ~idle;
   assign mbus_stb_o = access;
   assign mbus_we_o = (st_q == etct_pkg::ST_WRDAT) | (st_q == etct_pkg::ST_WB);
   assign mbus_size_o = (st_q == etct_pkg::ST_RDDAT || st_q == etct_pkg::ST_WRDAT) ? sz : etct_pkg::SZ_LONG;
   assign mbus_addr_o = (st_q == etct_pkg::ST_VEC) ? vec_addr :
                        (st_q == etct_pkg::ST_RDDAT) ? sar_q :
                        (st_q == etct_pkg::ST_WRDAT) ? dar_q : ctl_addr;
   assign mbus_wdata_o = (st_q == etct_pkg::ST_WB) ? wb_word : data_q;
   assign irq_o = |(istat_q & ien_q);

   // ============================================================
   // Checks
   chk_grant_before_access: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(mbus_stb_o) |-> $past(mbus_gnt_i) && $past(st_q) == etct_pkg::ST_REQ)
      else $error("access started without grant");
   chk_vector_address: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == etct_pkg::ST_VEC) |-> mbus_addr_o == vbase_q + 32'h00000400 + {22'h0, vnum_q, 2'h0})
      else $error("wrong vector address");
   chk_routed_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      act_go |=> !$rose(istat_q[0])) else $error("activation leaked to cpu");
   chk_result_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_result && !conv_done_i) |=> !cif.flag) else $error("result read left flag set");
   chk_writeback_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      dat_done |=> st_q == etct_pkg::ST_WB && widx_q == 2'h0 && mbus_we_o)
      else $error("no write-back after move");
   chk_count_decrement: assert property (@(posedge clk_i) disable iff (rst_i)
      dat_done |=> w0_q[15:0] == $past(w0_q[15:0]) - 16'h0001) else $error("count not decremented");
   chk_release_after_wb: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(mbus_req_o) |-> $past(st_q, 2) == etct_pkg::ST_WB && !$past(w0_q[20], 2))
      else $error("bus released early");
   chk_chain_next_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_last && w0_q[20]) |=> st_q == etct_pkg::ST_RDCTL && mbus_addr_o == $past(cia_q) + 32'h0000000C)
      else $error("chain did not read next set");
   chk_disarm_on_exhaust: assert property (@(posedge clk_i) disable iff (rst_i)
      (cpu_evt && trig_q && exh_q) |=> !trig_q && istat_q[0]) else $error("exhausted request not to cpu");
endmodule : etct_ctrl
`default_nettype wire

// ### tb/etct_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Internal bus memory: RAM, vector table and result registers
module etct_mem_model
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pacing of grant and answers
   input wire logic [3:0] gnt_dly_i,
   input wire logic [3:0] ack_dly_i,
   // Internal bus
   input wire logic req_i,
   output logic gnt_o,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [1:0] size_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o,
   output logic ack_o
);
   logic [31:0] mem [logic [31:0]];
   logic [32:0] log_q [$];
   int bad_cnt = 0;
   int long_cnt = 0;
   int gcnt;
   int acnt;

   // Grant and answer after a delay; idle read data toggles so stale data never looks valid
   always @(posedge clk_i)
   begin
      rdata_o <= ~rdata_o;
      ack_o <= 1'b0;
      if (rst_i)
      begin
         gnt_o <= 1'b0;
         rdata_o <= 32'h5A5A5A5A;
         gcnt = 0;
         acnt = 0;
      end
      else
      begin
         if (!req_i)
         begin
            gnt_o <= 1'b0;
            gcnt = 0;
         end
         else if (gcnt >= gnt_dly_i)
            gnt_o <= 1'b1;
         else
            gcnt++;
         if (stb_i && !ack_o)
         begin
            if (!gnt_o)
               bad_cnt++;
            if (acnt >= ack_dly_i)
            begin
               ack_o <= 1'b1;
               acnt = 0;
               log_q.push_back({we_i, addr_i});
               // Every access in these scenarios is a long word
               if (size_i == 2'h2)
                  long_cnt++;
               if (we_i)
                  mem[addr_i] = wdata_i;
               else
                  rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h00000000;
            end
            else
               acnt++;
         end
      end
   end
endmodule : etct_mem_model
`default_nettype wire

// ### tb/etct_ctrl_test.sv
`include "etct_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Testbench: registers over Wishbone, transfers seen in memory
module etct_ctrl_test;
   localparam logic [31:0] VB = 32'h00002000;
   localparam logic [31:0] VEC = 32'h00002414;
   localparam logic [31:0] CIA = 32'h00003000;
   localparam logic [31:0] S0 = 32'h00010000;
   localparam logic [31:0] S1 = 32'h00010004;
   localparam logic [31:0] D0 = 32'h00004000;
   localparam logic [31:0] D1 = 32'h00004100;
   localparam logic [31:0] W0A = 32'h001A0002;
   localparam logic [31:0] W0B = 32'h000A0002;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic conv_done = 1'b0;
   logic [3:0] gnt_dly = 4'h0;
   logic [3:0] ack_dly = 4'h0;
   logic mbus_req_o, mbus_gnt, mbus_stb_o, mbus_we_o, mbus_ack, irq_o, conv_start;
   logic [1:0] mbus_size_o;
   logic [31:0] mbus_addr_o, mbus_wdata_o, mbus_rdata;
   int error_cnt = 0;
   int n_compared = 0;

   etct_ctrl #(.RES_CH0_ADDR(S0), .RES_CH1_ADDR(S1)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_done_i(conv_done), .conv_start_o(conv_start),
      .mbus_req_o(mbus_req_o), .mbus_gnt_i(mbus_gnt), .mbus_stb_o(mbus_stb_o), .mbus_we_o(mbus_we_o),
      .mbus_size_o(mbus_size_o), .mbus_addr_o(mbus_addr_o), .mbus_wdata_o(mbus_wdata_o),
      .mbus_rdata_i(mbus_rdata), .mbus_ack_i(mbus_ack), .irq_o(irq_o));

   etct_mem_model mdl (.clk_i(clk_i), .rst_i(rst_i), .gnt_dly_i(gnt_dly), .ack_dly_i(ack_dly),
      .req_i(mbus_req_o), .gnt_o(mbus_gnt), .stb_i(mbus_stb_o), .we_i(mbus_we_o), .addr_i(mbus_addr_o),
      .size_i(mbus_size_o), .wdata_i(mbus_wdata_o), .rdata_o(mbus_rdata), .ack_o(mbus_ack));

   // 10 MHz clock
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One classic cycle; request held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 50)
         error_cnt++;
   endtask : wb

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      wb(1'b1, adr, dat, q);
   endtask : wr

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask, input string name);
      logic [31:0] q;
      wb(1'b0, adr, 32'h00000000, q);
      check(name, {1'b0, q & mask}, {1'b0, exp});
   endtask : rd

   task automatic pulse();
      @(posedge clk_i);
      conv_done <= 1'b1;
      @(posedge clk_i);
      conv_done <= 1'b0;
   endtask : pulse

   // Wait until every expected access is logged and the bus request is gone
   task automatic wait_seq(input int need);
      int n;
      n = 0;
      do @(posedge clk_i); while ((mdl.log_q.size() < need || mbus_req_o !== 1'b0) && ++n < 2000);
      if (n >= 2000)
         error_cnt++;
   endtask : wait_seq

   task automatic chk_log(input int b, input logic [31:0] d0, input logic [31:0] d1);
      logic [32:0] e [17];
      e = '{{1'b0, VEC}, {1'b0, CIA}, {1'b0, CIA + 32'h4}, {1'b0, CIA + 32'h8}, {1'b0, S0}, {1'b1, d0},
         {1'b1, CIA}, {1'b1, CIA + 32'h4}, {1'b1, CIA + 32'h8}, {1'b0, CIA + 32'hC}, {1'b0, CIA + 32'h10},
         {1'b0, CIA + 32'h14}, {1'b0, S1}, {1'b1, d1}, {1'b1, CIA + 32'hC}, {1'b1, CIA + 32'h10},
         {1'b1, CIA + 32'h14}};
      for (int i = 0; i < 17; i++)
         check("access order", mdl.log_q[b + i], e[i]);
   endtask : chk_log

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // Watchdog far beyond the expected few hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      complete_run();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      int n;
      mdl.mem[VEC] = CIA;
      mdl.mem[CIA] = W0A;
      mdl.mem[CIA + 32'h4] = S0;
      mdl.mem[CIA + 32'h8] = D0;
      mdl.mem[CIA + 32'hC] = W0B;
      mdl.mem[CIA + 32'h10] = S1;
      mdl.mem[CIA + 32'h14] = D1;
      mdl.mem[S0] = 32'h00001234;
      mdl.mem[S1] = 32'h00009ABC;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 32; a += 4)
         rd(8'(a), 32'h00000000, 32'hFFFFFFFF, "reset value");
      wr(`ETCT_OFF_VBASE, VB);
      rd(`ETCT_OFF_VBASE, VB, 32'hFFFFFFFF, "vector base");
      wr(`ETCT_OFF_VNUM, 32'h00000005);
      wr(`ETCT_OFF_IEN, 32'h00000001);
      wr(`ETCT_OFF_CTRL, 32'h00000007);
      // First activation, prompt partner
      pulse();
      wait_seq(17);
      chk_log(0, D0, D1);
      check("ch0 data", {1'b0, mdl.mem[D0]}, 33'h000001234);
      check("ch1 data", {1'b0, mdl.mem[D1]}, 33'h000009ABC);
      check("set0 count", {1'b0, mdl.mem[CIA]}, {1'b0, W0A - 32'h1});
      check("set0 dest", {1'b0, mdl.mem[CIA + 32'h8]}, {1'b0, D0 + 32'h4});
      check("set1 count", {1'b0, mdl.mem[CIA + 32'hC]}, {1'b0, W0B - 32'h1});
      check("bus slip", 33'(mdl.bad_cnt), 33'h0);
      check("long size", 33'(mdl.long_cnt), 33'h11);
      rd(`ETCT_OFF_STATUS, 32'h0, 32'h7, "status");
      rd(`ETCT_OFF_ISTAT, 32'h0, 32'h1, "cpu request");
      check("irq", 33'(irq_o), 33'h0);
      rd(`ETCT_OFF_CTRL, 32'h7, 32'h7, "scan on");
      check("start pin", 33'(conv_start), 33'h1);
      // Second activation, slow partner, new end mid-sequence
      gnt_dly <= 4'h4;
      ack_dly <= 4'h3;
      mdl.mem[S0] = 32'h00005678;
      pulse();
      n = 0;
      // Wait past the second result read, which would otherwise clear the new flag
      do @(posedge clk_i); while (mdl.log_q.size() < 30 && ++n < 2000);
      if (n >= 2000)
         error_cnt++;
      pulse();
      wait_seq(34);
      chk_log(17, D0 + 32'h4, D1 + 32'h4);
      check("ch0 data", {1'b0, mdl.mem[D0 + 32'h4]}, 33'h000005678);
      check("set0 count", {1'b0, mdl.mem[CIA]}, {1'b0, W0A - 32'h2});
      rd(`ETCT_OFF_CTRL, 32'h6, 32'h7, "disarm");
      rd(`ETCT_OFF_ISTAT, 32'h1, 32'h1, "cpu request");
      check("irq", 33'(irq_o), 33'h1);
      rd(`ETCT_OFF_STATUS, 32'h1, 32'h3, "pending flag");
      check("no activation", 33'(mdl.log_q.size()), 33'h22);
      // Handler stops the scan and clears the request
      wr(`ETCT_OFF_CTRL, 32'h00000000);
      wr(`ETCT_OFF_ICLR, 32'h00000001);
      rd(`ETCT_OFF_ISTAT, 32'h0, 32'h1, "cleared");
      rd(`ETCT_OFF_STATUS, 32'h0, 32'h1, "flag cleared");
      check("irq", 33'(irq_o), 33'h0);
      // Single scan with trigger off and interrupt masked
      wr(`ETCT_OFF_IEN, 32'h00000000);
      wr(`ETCT_OFF_CTRL, 32'h00000002);
      pulse();
      rd(`ETCT_OFF_CTRL, 32'h0, 32'h7, "single scan");
      check("start pin", 33'(conv_start), 33'h0);
      rd(`ETCT_OFF_ISTAT, 32'h1, 32'h1, "cpu request");
      check("irq masked", 33'(irq_o), 33'h0);
      wr(`ETCT_OFF_IEN, 32'h00000001);
      rd(`ETCT_OFF_ISTAT, 32'h1, 32'h1, "cpu request");
      check("irq", 33'(irq_o), 33'h1);
      check("no activation", 33'(mdl.log_q.size()), 33'h22);
      complete_run();
   end
endmodule : etct_ctrl_test
`default_nettype wire
